/* File: logic/psl_top.sv */
// Purpose: Peripheral-to-pin routing selections guarded by a keyed lock bit.
// Assumes: Write ports come from core logic on clk_sys_i; fuse is a static strap.
// Notes:   Power-on reset restores defaults, other resets keep the selections.
//
// Notes on behaviour
// - Only four dedicated pins have bus buffers; others use their threshold setting.
// - Two-wire bus mode on a dedicated pin that a bus input is routed to overrides its threshold selection.
// - While locked, every input and output routing selection is frozen.
// - Selection writes are ignored while locked and accepted once unlocked.
// - Lock bit changes only after writing 0x55 then 0xAA to the lock register.
// - With the one-time fuse, the bit may be set only once per reset.
// - With the fuse, once set the bit stays set until the next reset.
// - Sleep leaves every routing selection unchanged.
// - Power-on reset restores default selections and removes any permanent lock.
// - Any other reset keeps the current routing selections.
module psl_top
(
    // Clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          reset_i,
    input  wire logic          por_i,
    // Configuration strap
    input  wire logic          one_time_lock_fuse_i,
    // Lock register write
    input  wire logic          lock_wr_i,
    input  wire logic [7:0]    lock_data_i,
    // Selection write
    input  wire logic          sel_wr_i,
    input  wire logic          sel_is_out_i,
    input  wire logic [4:0]    sel_idx_i,
    input  wire logic [4:0]    sel_data_i,
    // Pad threshold control
    input  wire logic [23:0]   input_threshold_select_i,
    input  wire logic          bus_mode_i,
    // Routing state
    output logic [19:0]        in_sel_o,
    output logic [119:0]       out_fn_o,
    output logic               routing_lock_bit_o,
    output logic               sel_wr_refused_o,
    output logic               lock_refused_o,
    // Pad buffer selection
    output logic [23:0]        bus_buf_en_o,
    output logic [23:0]        schmitt_sel_o
);
    localparam int unsigned NI = psl_pkg::IN_CNT;
    localparam int unsigned NP = psl_pkg::PIN_CNT;
    localparam int unsigned PW = psl_pkg::PIN_W;
    localparam int unsigned FW = psl_pkg::FN_W;

    psl_lock_if lk ();

    logic          fuse_s1_r;
    logic          fuse_s2_r;
    logic [PW-1:0] in_sel_r [NI];
    logic [FW-1:0] out_fn_r [NP];
    logic          sel_ok;
    logic [NP-1:0] bus_pin;
    logic [NP-1:0] bus_buf_nxt;
    logic [NP-1:0] schmitt_nxt;

    // The strap comes from outside the clock domain.
    always_ff @(posedge clk_sys_i)
    begin
        fuse_s1_r <= one_time_lock_fuse_i;
        fuse_s2_r <= fuse_s1_r;
    end

    assign lk.wr   = lock_wr_i;
    assign lk.data = lock_data_i;

    // A power-on reset clears the permanent lock together with every other reset.
    psl_lock u_lock
    (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .fuse_i    (fuse_s2_r),
        .lk        (lk.keeper)
    );

    assign sel_ok = sel_wr_i && !lk.locked;

    // Selections hold their value in every state, sleep included; only a write or a power-on reset moves them.
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i && por_i)
        begin
            in_sel_r[psl_pkg::IN_BUS_CLK]  <= psl_pkg::DEF_BUS_CLK;
            in_sel_r[psl_pkg::IN_BUS_DATA] <= psl_pkg::DEF_BUS_DATA;
            in_sel_r[psl_pkg::IN_UART_RX]  <= psl_pkg::DEF_UART_RX;
            in_sel_r[psl_pkg::IN_UART_CK]  <= psl_pkg::DEF_UART_CK;
        end
        else if (!reset_i && sel_ok && !sel_is_out_i && sel_idx_i < 5'(NI))
            in_sel_r[sel_idx_i[1:0]] <= sel_data_i;
    end

    genvar g;
    generate
        for (g = 0; g < NP; g++)
        begin : g_pin
            always_ff @(posedge clk_sys_i)
            begin
                if (reset_i && por_i)
                    out_fn_r[g] <= psl_pkg::DEF_OUT_FN;
                else if (!reset_i && sel_ok && sel_is_out_i && sel_idx_i == 5'(g))
                    out_fn_r[g] <= sel_data_i;
            end

            // A pin counts as a bus pin when either bus input is routed to it.
            assign bus_pin[g] = (in_sel_r[psl_pkg::IN_BUS_CLK] == 5'(g))
                             || (in_sel_r[psl_pkg::IN_BUS_DATA] == 5'(g));
            assign bus_buf_nxt[g] = bus_mode_i && bus_pin[g] && psl_pkg::BUS_BUF_PINS[g];
            assign schmitt_nxt[g] = bus_buf_nxt[g] ? 1'b0 : input_threshold_select_i[g];

            always_ff @(posedge clk_sys_i)
            begin
                if (reset_i)
                begin
                    bus_buf_en_o[g]  <= 1'b0;
                    schmitt_sel_o[g] <= 1'b1;
                end
                else
                begin
                    bus_buf_en_o[g]  <= bus_buf_nxt[g];
                    schmitt_sel_o[g] <= schmitt_nxt[g];
                end
            end
        end
    endgenerate

    // Routing outputs mirror the selection flops one cycle later so outputs stay registered.
    always_ff @(posedge clk_sys_i)
    begin
        for (int i = 0; i < NI; i++)
            in_sel_o[i*PW +: PW] <= in_sel_r[i];
        for (int p = 0; p < NP; p++)
            out_fn_o[p*FW +: FW] <= out_fn_r[p];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            routing_lock_bit_o <= 1'b0;
            sel_wr_refused_o   <= 1'b0;
            lock_refused_o     <= 1'b0;
        end
        else
        begin
            routing_lock_bit_o <= lk.locked;
            sel_wr_refused_o   <= sel_wr_i && lk.locked;
            lock_refused_o     <= lk.rejected;
        end
    end
endmodule

/* File: logic/psl_pkg.sv */
// Purpose: Shared constants for the peripheral pin routing block.
// Assumes: One 50 MHz clock, synchronous active-high reset.
// Notes:   Pins are numbered port A 0..7, port B 8..15, port C 16..23.
package psl_pkg;
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned PIN_CNT     = 24;
    localparam int unsigned PIN_W       = 5;
    localparam int unsigned FN_W        = 5;
    localparam int unsigned IN_CNT      = 4;
    localparam int unsigned DATA_W      = 8;

    // Peripheral inputs that can be routed.
    localparam logic [1:0] IN_BUS_CLK   = 2'h0;
    localparam logic [1:0] IN_BUS_DATA  = 2'h1;
    localparam logic [1:0] IN_UART_RX   = 2'h2;
    localparam logic [1:0] IN_UART_CK   = 2'h3;

    // Default input pins and output function after power-on reset.
    localparam logic [4:0] DEF_BUS_CLK  = 5'h13;
    localparam logic [4:0] DEF_BUS_DATA = 5'h14;
    localparam logic [4:0] DEF_UART_RX  = 5'h17;
    localparam logic [4:0] DEF_UART_CK  = 5'h16;
    localparam logic [4:0] DEF_OUT_FN   = 5'h00;

    // Pins that carry the dedicated two-wire bus input buffers.
    localparam logic [23:0] BUS_BUF_PINS = 24'h180600;

    // Unlock key and lock field.
    localparam logic [7:0] KEY_FIRST    = 8'h55;
    localparam logic [7:0] KEY_SECOND   = 8'hAA;
    localparam int unsigned LOCK_BIT_POS = 0;

    typedef enum logic [1:0]
    {
        PSL_IDLE  = 2'b00,
        PSL_KEY1  = 2'b01,
        PSL_ARMED = 2'b10
    } psl_key_state_t;
endpackage

/* File: logic/psl_lock_if.sv */
// Purpose: Carries lock-register writes to the lock keeper and its state back.
// Assumes: Same clock on both sides.
// Notes:   Strobes are one-cycle pulses.
interface psl_lock_if;
    logic       wr;
    logic [7:0] data;
    logic       locked;
    logic       rejected;

    modport keeper
    (
        input  wr,
        input  data,
        output locked,
        output rejected
    );
    modport core
    (
        output wr,
        output data,
        input  locked,
        input  rejected
    );
endinterface

/* File: logic/psl_lock.sv */
// Purpose: Unlock key sequencer and routing lock bit with optional one-time lock.
// Assumes: fuse_i is already synchronised and steady outside reset.
// Notes:   Any reset clears the lock bit and the one-time history.
module psl_lock
(
    // Clock and reset
    input  wire logic     clk_sys_i,
    input  wire logic     reset_i,
    // Configuration
    input  wire logic     fuse_i,
    // Lock register channel
    psl_lock_if.keeper    lk
);
    psl_pkg::psl_key_state_t state_r;
    logic                    fuse_r;
    logic                    perm_r;
    logic                    bit_req;
    logic                    change_ok;

    assign bit_req   = lk.data[psl_pkg::LOCK_BIT_POS];
    // Once the one-time fuse has seen the bit set, nothing but a reset moves it again.
    assign change_ok = !(fuse_r && perm_r);

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            fuse_r <= fuse_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            state_r <= psl_pkg::PSL_IDLE;
        else if (lk.wr)
        begin
            unique case (state_r)
                psl_pkg::PSL_IDLE:
                    state_r <= (lk.data == psl_pkg::KEY_FIRST) ? psl_pkg::PSL_KEY1 : psl_pkg::PSL_IDLE;
                psl_pkg::PSL_KEY1:
                    state_r <= (lk.data == psl_pkg::KEY_SECOND) ? psl_pkg::PSL_ARMED : psl_pkg::PSL_IDLE;
                psl_pkg::PSL_ARMED:
                    state_r <= psl_pkg::PSL_IDLE;
                default:
                    state_r <= psl_pkg::PSL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            lk.locked <= 1'b0;
        else if (lk.wr && state_r == psl_pkg::PSL_ARMED && change_ok)
            lk.locked <= bit_req;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            perm_r <= 1'b0;
        else if (lk.wr && state_r == psl_pkg::PSL_ARMED && bit_req)
            perm_r <= 1'b1;
    end

    // Reports an armed bit change that the one-time lock refused.
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            lk.rejected <= 1'b0;
        else
            lk.rejected <= lk.wr && state_r == psl_pkg::PSL_ARMED && !change_ok;
    end
endmodule

/* File: dv/psl_chk.sv */
// Purpose: Port checks of the routing lock block.
// Assumes: The fuse strap moves only while reset is high.
// Notes:   The lock output lags the internal bit by one edge.
module psl_chk
(
    // Watched ports
    input wire logic         clk_sys_i,
    input wire logic         reset_i,
    input wire logic         one_time_lock_fuse_i,
    input wire logic         lock_wr_i,
    input wire logic [7:0]   lock_data_i,
    input wire logic         sel_wr_i,
    input wire logic [23:0]  input_threshold_select_i,
    input wire logic         bus_mode_i,
    input wire logic [19:0]  in_sel_o,
    input wire logic [119:0] out_fn_o,
    input wire logic         routing_lock_bit_o,
    input wire logic         sel_wr_refused_o,
    input wire logic         lock_refused_o,
    input wire logic [23:0]  bus_buf_en_o,
    input wire logic [23:0]  schmitt_sel_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    a_refuse_has_write: assert property (sel_wr_refused_o |-> $past(sel_wr_i))
        else $error("selection refusal without a write");
    a_locked_refuses: assert property (sel_wr_i && routing_lock_bit_o && !$past(lock_wr_i) |=> sel_wr_refused_o)
        else $error("selection write taken while locked");
    a_frozen_sel: assert property (routing_lock_bit_o [*3] |-> $stable(out_fn_o) && $stable(in_sel_o))
        else $error("selection moved while locked");
    a_lock_set_key: assert property ($rose(routing_lock_bit_o) |-> $past(lock_wr_i, 2) && $past(lock_data_i[0], 2))
        else $error("lock set without a bit write");
    a_lock_clr_key: assert property ($fell(routing_lock_bit_o) |-> $past(lock_wr_i, 2) && !$past(lock_data_i[0], 2))
        else $error("lock cleared without a bit write");
    a_fuse_hold: assert property (one_time_lock_fuse_i && routing_lock_bit_o |=> routing_lock_bit_o)
        else $error("one-time lock released");
    a_refuse_cause: assert property (lock_refused_o |-> $past(lock_wr_i, 2) && $past(one_time_lock_fuse_i, 2) && routing_lock_bit_o)
        else $error("lock refusal without cause");
    a_bus_buf_pins: assert property (|bus_buf_en_o |-> $past(bus_mode_i) && !(bus_buf_en_o & ~psl_pkg::BUS_BUF_PINS))
        else $error("bus buffer on a plain pin");
    a_schmitt_follow: assert property (!$past(reset_i) |-> schmitt_sel_o == ($past(input_threshold_select_i) & ~bus_buf_en_o))
        else $error("threshold select wrong");
    cover property ($rose(routing_lock_bit_o));
    cover property (lock_refused_o);
    cover property (sel_wr_refused_o);
endmodule

/* File: dv/test_pin_select_lock.sv */
// Purpose: Self-checking bench for the routing lock block.
// Assumes: Writes are one-cycle pulses launched at the falling edge.
// Notes:   Sleep has no port, so a long idle stands in for it.
module test_pin_select_lock;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_sys_i = 1'b0, reset_i = 1'b1, por_i = 1'b1, one_time_lock_fuse_i = 1'b0;
    logic         lock_wr_i = 1'b0, sel_wr_i = 1'b0, sel_is_out_i = 1'b0, bus_mode_i = 1'b0;
    logic [7:0]   lock_data_i = 8'h00, rnd = 8'h54;
    logic [4:0]   sel_idx_i = 5'h00, sel_data_i = 5'h00;
    logic [23:0]  input_threshold_select_i = 24'h000000, bus_buf_en_o, schmitt_sel_o;
    logic [19:0]  in_sel_o, ei;
    logic [119:0] out_fn_o, eo;
    logic         routing_lock_bit_o, sel_wr_refused_o, lock_refused_o, el = 1'b0;
    int           failures = 0, comparisons = 0;

    psl_top dut (.*);
    always #10 clk_sys_i = ~clk_sys_i;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Only the clock and data selections can claim a dedicated buffer.
    function automatic logic [23:0] buf_exp(input logic [19:0] s);
        buf_exp = 24'h000000;
        for (int k = 0; k < 2; k++)
            buf_exp[s[5*k+:5]] = psl_pkg::BUS_BUF_PINS[s[5*k+:5]];
    endfunction
    task automatic chk(input logic [119:0] got, input logic [119:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic lw(input logic [7:0] d);
        @(negedge clk_sys_i);
        {lock_wr_i, lock_data_i} = {1'b1, d};
        @(negedge clk_sys_i);
        lock_wr_i = 1'b0;
    endtask
    task automatic key(input logic [7:0] d);
        lw(8'h55);
        lw(8'hAA);
        lw(d);
        @(negedge clk_sys_i);
    endtask
    task automatic sw(input logic o, input logic [4:0] i, input logic [4:0] d);
        @(negedge clk_sys_i);
        {sel_wr_i, sel_is_out_i, sel_idx_i, sel_data_i} = {1'b1, o, i, d};
        @(negedge clk_sys_i);
        sel_wr_i = 1'b0;
        chk(sel_wr_refused_o, el);
        if (!el && o && i < 5'h18) eo[5*i+:5] = d;
        if (!el && !o && i < 5'h04) ei[5*i+:5] = d;
        @(negedge clk_sys_i);
        chk(out_fn_o, eo);
        chk(in_sel_o, ei);
        chk(bus_buf_en_o, buf_exp(ei) & {24{bus_mode_i}});
        chk(schmitt_sel_o, input_threshold_select_i & ~(buf_exp(ei) & {24{bus_mode_i}}));
    endtask
    task automatic rs(input logic p);
        @(negedge clk_sys_i);
        {reset_i, por_i} = {1'b1, p};
        repeat (8) @(negedge clk_sys_i);
        {reset_i, por_i, el} = 3'h0;
        if (p) ei = {psl_pkg::DEF_UART_CK, psl_pkg::DEF_UART_RX, psl_pkg::DEF_BUS_DATA, psl_pkg::DEF_BUS_CLK};
        if (p) eo = {24{psl_pkg::DEF_OUT_FN}};
        @(negedge clk_sys_i);
        chk(in_sel_o, ei);
        chk(out_fn_o, eo);
        chk(routing_lock_bit_o, 1'b0);
    endtask
    task automatic wrap_up;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        wrap_up();
    end
    initial
    begin
        rs(1'b1);
        for (int n = 0; n < 40; n++)
        begin
            rnd = lfsr(rnd);
            sw(rnd[0], rnd[0] ? rnd[7:3] : rnd[4:3], {rnd[2:0], rnd[7:6]});
            if (n == 20) input_threshold_select_i = {rnd, ~rnd, rnd};
            if (n == 20) bus_mode_i = 1'b1;
        end
        sw(1'b0, 5'h00, 5'h05);
        sw(1'b0, 5'h01, 5'h0A);
        sw(1'b0, 5'h03, 5'h10);
        sw(1'b1, 5'h10, 5'h07);
        lw(8'h01);
        key(8'h00);
        chk(routing_lock_bit_o, 1'b0);
        lw(8'h55);
        lw(8'h00);
        lw(8'hAA);
        lw(8'h01);
        @(negedge clk_sys_i);
        chk(routing_lock_bit_o, 1'b0);
        key(8'h01);
        chk(routing_lock_bit_o, 1'b1);
        el = 1'b1;
        sw(1'b1, 5'h02, 5'h1F);
        sw(1'b0, 5'h02, 5'h01);
        key(8'h00);
        el = 1'b0;
        chk(routing_lock_bit_o, 1'b0);
        sw(1'b1, 5'h17, 5'h0C);
        rs(1'b0);
        repeat (50) @(negedge clk_sys_i);
        chk(out_fn_o, eo);
        one_time_lock_fuse_i = 1'b1;
        rs(1'b0);
        key(8'h01);
        chk(routing_lock_bit_o, 1'b1);
        key(8'h00);
        chk(lock_refused_o, 1'b1);
        chk(routing_lock_bit_o, 1'b1);
        rs(1'b1);
        key(8'h01);
        chk(routing_lock_bit_o, 1'b1);
        wrap_up();
    end
endmodule

bind psl_top psl_chk u_chk (.*);
